// ==== adcp_host_port.sv ====
// Purpose: conversion control and result readout of six channels
// Assumes: all pins synchronous to clk; sampleCode from the analog core
// Notes: serial lanes carry channel pairs 0/1, 2/3, 4/5
// What this block and the host must do
// R1 - conversion lasts three microseconds, internally timed
// R2 - host waits 150 ns before next start
// R3 - host holds start low 25 ns
// R4 - busy rises within 60 ns of start
// R5 - host waits wake-up time after standby
// R6 - read data valid within 45 ns
// R7 - data held, bus released after read
// R8 - host spaces parallel reads 6 ns
// R9 - control write captured on write rising edge
// R10 - host serial clock at most 18 MHz
// R11 - serial outputs enabled after select falls
// R12 - new serial bit after clock rise
// R13 - serial bit held through falling edge
// R14 - serial outputs released after select rises
// R15 - drive result while select and read low
// R16 - write control while select and write low
// R17 - host reads only after busy falls
// R18 - 16-bit words, one per read, MSB first
`timescale 1ns/1ps
`include "adcp_defs.svh"
module adcp_host_port (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [2:0] convStart,
  input wire logic standbyN,
  input wire logic interfaceSelect,
  input wire logic csN,
  input wire logic rdN,
  input wire logic wrN,
  input wire logic [15:0] parallelDataIn,
  input wire logic serialClk,
  input wire logic [95:0] sampleCode,
  output logic busy,
  output logic [15:0] parallelDataOut,
  output logic parallelDataOe,
  output logic [2:0] serialDataOut,
  output logic serialDataOe,
  output logic [15:0] controlWord
);
  // ----------------------------------------
  // conversion
  // ----------------------------------------
  adcp_pkg::adcp_state_t state_q, state_d;
  logic [`ADCP_CNT_W-1:0] cnt_q, cnt_d;
  logic [2:0] convPrev_q, convPrev_d, pairs_q, pairs_d, startRise;
  logic busy_q, busy_d, convDone;
  adcp_pkg::adcp_words_t result_q, result_d;

  assign startRise = convStart & ~convPrev_q;
  assign convDone = (state_q == adcp_pkg::ST_CONV) &&
    (cnt_q == `ADCP_CNT_W'(`ADCP_TCONV_CYC - 1));

  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    pairs_d = pairs_q;
    busy_d = busy_q;
    result_d = result_q;
    convPrev_d = convStart;
    unique case (state_q)
      adcp_pkg::ST_DOWN:
      begin
        if (standbyN)
          state_d = adcp_pkg::ST_IDLE;
      end
      adcp_pkg::ST_IDLE:
      begin
        if (!standbyN)
          state_d = adcp_pkg::ST_DOWN;
        // R4 - busy on start
        else if (|startRise)
        begin
          state_d = adcp_pkg::ST_CONV;
          cnt_d = '0;
          pairs_d = startRise;
          busy_d = 1'b1;
        end
      end
      adcp_pkg::ST_CONV:
      begin
        // R1 - internal conversion count
        if (convDone)
        begin
          state_d = adcp_pkg::ST_IDLE;
          busy_d = 1'b0;
          for (int i = 0; i < 6; i++)
            if (pairs_q[i/2])
              result_d[i] = sampleCode[i*16 +: 16];
        end
        else
          cnt_d = `ADCP_CNT_W'(cnt_q + 1'b1);
      end
    endcase
  end

  // starts during a conversion are ignored; standby waits for its end
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      state_q <= adcp_pkg::ST_IDLE;
      cnt_q <= '0;
      pairs_q <= '0;
      busy_q <= 1'b0;
      result_q <= '0;
      convPrev_q <= 3'h7;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      pairs_q <= pairs_d;
      busy_q <= busy_d;
      result_q <= result_d;
      convPrev_q <= convPrev_d;
    end
  end

  // ----------------------------------------
  // parallel and serial readout
  // ----------------------------------------
  function automatic logic [2:0] serBits(input logic [4:0] idx,
    input adcp_pkg::adcp_words_t w);
    logic [2:0] b;
    b = '0;
    for (int l = 0; l < 3; l++)
      b[l] = w[2*l + idx[4]][4'hf - idx[3:0]];
    return b;
  endfunction

  logic readOn, readEnd, wrRise, frame, sclkRise;
  logic wrPrev_q, wrPrev_d, csPrev_q, csPrev_d, sclkPrev_q, sclkPrev_d;
  logic [15:0] wrData_q, wrData_d, ctrl_q, ctrl_d, parOut_q, parOut_d;
  logic [2:0] rdPtr_q, rdPtr_d, serOut_q, serOut_d;
  logic [4:0] serBit_q, serBit_d;
  logic parOe_q, parOe_d, serOe_q, serOe_d;

  assign readOn = !interfaceSelect && !csN && !rdN;
  assign readEnd = parOe_q && !readOn;
  assign wrRise = !interfaceSelect && wrN && !wrPrev_q && !csPrev_q;
  assign frame = interfaceSelect && !csN;
  assign sclkRise = serialClk && !sclkPrev_q;

  always_comb
  begin
    wrPrev_d = wrN;
    csPrev_d = csN;
    sclkPrev_d = serialClk;
    wrData_d = wrData_q;
    ctrl_d = ctrl_q;
    parOut_d = parOut_q;
    rdPtr_d = rdPtr_q;
    // R13 - bit held until next rise
    serOut_d = serOut_q;
    serBit_d = serBit_q;
    // R15 - drive while selected
    // R7 - enable drops when strobe ends
    parOe_d = readOn;
    // R6 - word out next edge
    if (readOn)
      parOut_d = result_q[rdPtr_q];
    // R18 - one channel per strobe
    if (readEnd)
      rdPtr_d = (rdPtr_q == `ADCP_LAST_CH) ? 3'h0 : 3'(rdPtr_q + 1'b1);
    // a fresh result set always starts at channel 0
    if (convDone)
      rdPtr_d = 3'h0;
    // R16 - data taken while strobed
    if (!interfaceSelect && !csN && !wrN)
      wrData_d = parallelDataIn;
    // R9 - commit on write rise
    if (wrRise)
      ctrl_d = wrData_q;
    serOe_d = serOe_q;
    if (!frame)
    begin
      // R14 - release on select high
      serOe_d = 1'b0;
      serBit_d = 5'h00;
    end
    else if (!serOe_q)
    begin
      // R11 - enable and first bit
      serOe_d = 1'b1;
      serBit_d = 5'h00;
      serOut_d = serBits(5'h00, result_q);
    end
    // R12 - next bit on clock rise
    else if (sclkRise)
    begin
      serBit_d = 5'(serBit_q + 1'b1);
      serOut_d = serBits(5'(serBit_q + 1'b1), result_q);
    end
  end

  // data keeps its value after release, giving the hold time
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      wrPrev_q <= 1'b1;
      csPrev_q <= 1'b1;
      sclkPrev_q <= 1'b0;
      wrData_q <= '0;
      ctrl_q <= `ADCP_CTRL_RST;
      parOut_q <= '0;
      rdPtr_q <= 3'h0;
      serOut_q <= 3'h0;
      serBit_q <= 5'h00;
      parOe_q <= 1'b0;
      serOe_q <= 1'b0;
    end
    else
    begin
      wrPrev_q <= wrPrev_d;
      csPrev_q <= csPrev_d;
      sclkPrev_q <= sclkPrev_d;
      wrData_q <= wrData_d;
      ctrl_q <= ctrl_d;
      parOut_q <= parOut_d;
      rdPtr_q <= rdPtr_d;
      serOut_q <= serOut_d;
      serBit_q <= serBit_d;
      parOe_q <= parOe_d;
      serOe_q <= serOe_d;
    end
  end

  assign busy = busy_q;
  assign parallelDataOut = parOut_q;
  assign parallelDataOe = parOe_q;
  assign serialDataOut = serOut_q;
  assign serialDataOe = serOe_q;
  assign controlWord = ctrl_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_BUSY_RISE: // R4
    assert property (state_q == adcp_pkg::ST_IDLE && standbyN &&
      |startRise |=> busy_q)
    else $error("busy did not follow start");
  AST_CONV_LEN: // R1
    assert property ($fell(busy_q) && $past(rst_b) |->
      $past(cnt_q) == `ADCP_CNT_W'(`ADCP_TCONV_CYC - 1))
    else $error("conversion length wrong");
  AST_RD_DRIVE: // R15
    assert property (readOn |=> parOe_q && parOut_q == $past(result_q[rdPtr_q]))
    else $error("read not driven");
  AST_RD_RELEASE: // R7
    assert property (readEnd |=> !parOe_q && $stable(parOut_q))
    else $error("bus not released or data lost");
  AST_WR_CAPTURE: // R9
    assert property (wrRise |=> ctrl_q == $past(wrData_q))
    else $error("control write missed");
  AST_SER_ENABLE: // R11
    assert property (frame && !serOe_q |=> serOe_q && serBit_q == 5'h00)
    else $error("serial enable late");
  AST_SER_OFF: // R14
    assert property (serOe_q && csN |=> !serOe_q)
    else $error("serial not released");
  AST_SER_STEP: // R12
    assert property (serOe_q && frame && sclkRise |=>
      serBit_q == 5'($past(serBit_q) + 1'b1))
    else $error("serial bit not advanced");
  AST_SER_HOLD: // R13
    assert property (serOe_q && frame && !sclkRise |=> $stable(serOut_q))
    else $error("serial bit changed without clock rise");
endmodule

// ==== adcp_defs.svh ====
// Purpose: constants of the converter host port
// Assumes: 40 MHz core clock
// Notes: cycle counts derive from the printed times
`ifndef ADCP_DEFS_SVH
`define ADCP_DEFS_SVH
`define ADCP_CLK_NS 25
`define ADCP_TCONV_NS 3000
`define ADCP_TCONV_CYC ((`ADCP_TCONV_NS + `ADCP_CLK_NS - 1) / `ADCP_CLK_NS)
`define ADCP_BUSY_MAX_NS 60
`define ADCP_BUSY_CYC (`ADCP_BUSY_MAX_NS / `ADCP_CLK_NS)
`define ADCP_RELQ_NS 12
`define ADCP_RELQ_CYC ((`ADCP_RELQ_NS / `ADCP_CLK_NS) > 0 ? \
  (`ADCP_RELQ_NS / `ADCP_CLK_NS) : 1)
`define ADCP_CNT_W 8
`define ADCP_LAST_CH 3'h5
`define ADCP_CTRL_RST 16'h0000
`endif

// ==== adcp_pkg.sv ====
// Purpose: types of the converter host port
// Assumes: nothing
// Notes: one-hot conversion states
package adcp_pkg;
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'h1,
    ST_CONV = 3'h2,
    ST_DOWN = 3'h4
  } adcp_state_t;
  typedef logic [5:0][15:0] adcp_words_t;
endpackage

// ==== adcp_host_model.sv ====
// Purpose: host side serial clock source
// Assumes: clk at 40 MHz
// Notes: clock stands low outside frames
`timescale 1ns/1ps
module adcp_host_model (
  input wire logic clk,
  input wire logic run,
  output logic serialClk
);
  logic [1:0] divQ;
  initial
  begin
    divQ = 2'h0;
    serialClk = 1'b0;
  end
  // 10 MHz rate
  // four clk per period keeps well under the ceiling
  always @(posedge clk)
  begin
    divQ <= run ? divQ + 2'h1 : 2'h0;
    serialClk <= run & divQ[1];
  end
endmodule

// ==== tb_adcp_host_port.sv ====
// Purpose: self-checking bench of the host port
// Assumes: 40 MHz clk, inputs driven at falling edge
// Notes: serial checks cover all three lanes
`timescale 1ns/1ps
module tb_adcp_host_port;
  logic clk = 1'b0, rst_b = 1'b0, csN = 1'b1, rdN = 1'b1, wrN = 1'b1;
  logic standbyN = 1'b1, interfaceSelect = 1'b0, busy, parallelDataOe;
  logic serialClk, serialDataOe;
  logic [2:0] convStart = 3'h0, serialDataOut;
  logic [15:0] parallelDataIn = 16'h0000, parallelDataOut, controlWord;
  logic [95:0] sampleCode;
  logic [31:0] got [3];
  int num_errors = 0, checks_done = 0, n;
  logic [2:0] rowCh [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h0};
  always #12.5 clk = ~clk;
  function automatic logic [15:0] word(input logic [2:0] c);
    return {4'ha, 1'b0, c, 8'h5c};
  endfunction
  initial for (int i = 0; i < 6; i++) sampleCode[16*i+:16] = word(i[2:0]);
  adcp_host_port i_adcp_host_port (.clk, .rst_b, .convStart, .standbyN,
    .interfaceSelect, .csN, .rdN, .wrN, .parallelDataIn, .serialClk,
    .sampleCode, .busy, .parallelDataOut, .parallelDataOe, .serialDataOut,
    .serialDataOe, .controlWord);
  adcp_host_model i_adcp_host_model (.clk, .run(!csN && interfaceSelect),
    .serialClk);
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic end_of_test();
    if (num_errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bound(input logic ok);
    if (!ok)
    begin
      num_errors++;
      end_of_test();
    end
  endtask
  // a hung flag ends the run instead of stalling it
  task automatic waitFor(ref logic s, input logic v);
    for (n = 0; n < 200 && s !== v; n++) @(negedge clk);
    bound(s === v);
  endtask
  task automatic rdWord(input logic [15:0] e);
    csN = 1'b0;
    rdN = 1'b0;
    waitFor(parallelDataOe, 1'b1);
    chk("accessCycles", 1, n);
    chk("parallelDataOut", e, parallelDataOut);
    rdN = 1'b1;
    csN = 1'b1;
    waitFor(parallelDataOe, 1'b0);
    chk("releaseCycles", 1, n);
    @(negedge clk);
  endtask
  task automatic wrCtl(input logic [15:0] d);
    parallelDataIn = d;
    csN = 1'b0;
    wrN = 1'b0;
    @(negedge clk);
    wrN = 1'b1;
    @(negedge clk);
    csN = 1'b1;
    parallelDataIn = 16'h0000;
    @(negedge clk);
  endtask
  task automatic nextBit();
    logic p;
    p = serialClk;
    for (n = 0; n < 8; n++)
    begin
      @(negedge clk);
      if (serialClk === 1'b1 && p === 1'b0)
        break;
      p = serialClk;
    end
    bound(n < 8);
    for (int l = 0; l < 3; l++)
      got[l] = {got[l][30:0], serialDataOut[l]};
  endtask
  initial
  begin
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    chk("resetState", 0, {busy, parallelDataOe, serialDataOe, controlWord});
    // start seen low once after release before it may rise
    @(negedge clk);
    convStart = 3'h7;
    waitFor(busy, 1'b1);
    chk("busyDelay", 1, n);
    convStart = 3'h0;
    repeat (3) @(negedge clk);
    convStart = 3'h7;
    waitFor(busy, 1'b0);
    chk("busyCycles", 117, n);
    repeat (6) @(negedge clk);
    chk("noRestart", 0, busy);
    convStart = 3'h0;
    for (int r = 0; r < 7; r++) rdWord(word(rowCh[r]));
    wrCtl(16'hc3a5);
    chk("controlWord", 16'hc3a5, controlWord);
    interfaceSelect = 1'b1;
    csN = 1'b0;
    waitFor(serialDataOe, 1'b1);
    chk("serialEnable", 1, n);
    for (int i = 0; i < 32; i++) nextBit();
    chk("serialLane0", {word(3'h0), word(3'h1)}, got[0]);
    chk("serialLane1", {word(3'h2), word(3'h3)}, got[1]);
    chk("serialLane2", {word(3'h4), word(3'h5)}, got[2]);
    csN = 1'b1;
    waitFor(serialDataOe, 1'b0);
    chk("serialRelease", 1, n);
    wrCtl(16'h0f0f);
    chk("serialWrite", 16'hc3a5, controlWord);
    // standby refuses starts, then one pair converts alone
    interfaceSelect = 1'b0;
    standbyN = 1'b0;
    repeat (2) @(negedge clk);
    convStart = 3'h1;
    repeat (3) @(negedge clk);
    chk("standbyRefuse", 0, busy);
    convStart = 3'h0;
    standbyN = 1'b1;
    sampleCode[15:0] = 16'h1234;
    sampleCode[47:32] = 16'h5678;
    repeat (1000) @(negedge clk);
    convStart = 3'h1;
    waitFor(busy, 1'b1);
    chk("wakeStart", 1, n);
    waitFor(busy, 1'b0);
    chk("pairCycles", 120, n);
    rdWord(16'h1234);
    rdWord(word(3'h1));
    rdWord(word(3'h2));
    // reset in mid conversion
    convStart = 3'h0;
    repeat (6) @(negedge clk);
    convStart = 3'h7;
    waitFor(busy, 1'b1);
    chk("midStart", 1, n);
    rst_b = 1'b0;
    @(negedge clk);
    rst_b = 1'b1;
    chk("midReset", 0, {busy, parallelDataOe, serialDataOe, controlWord});
    repeat (3) @(negedge clk);
    chk("noStartAtRelease", 0, busy);
    end_of_test();
  end
endmodule
